// file: ofd_decoder_properties.sv
`timescale 1ns/1ps
module ofd_decoder_props #(
  parameter int unsigned CNT_W = 16
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  // decode
  input wire logic [15:0] op_word,
  input wire logic op_valid,
  input wire ofd_pkg::ofd_decode_type dec,
  input wire logic dec_valid,
  input wire logic dec_unknown
);
  logic [15:0] w_q;
  logic v_q;
  logic pv;
  logic sub;
  logic ln_c;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      w_q <= 16'h0000;
      v_q <= 1'b0;
    end
    else
    begin
      w_q <= op_word;
      v_q <= op_valid;
    end
  end
  // pipeline word that produced this pulse
  always_comb
  begin
    pv = dec_valid && v_q;
    sub = pv && dec.op == ofd_pkg::OP_SUBTRACT_WITH_EXTEND;
    ln_c = pv && w_q[15:12] == 4'hC;
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_sub_size: assert property (
    sub |-> dec.size == w_q[7:6]) else $error("sub size");
  a_sub_loc: assert property (
    sub |-> dec.mem_to_mem == w_q[3]) else $error("sub location");
  a_sub_regs: assert property (
    sub |-> {dec.predec, dec.x_is_addr, dec.y_is_addr} == {3{w_q[3]}}) else $error("sub regs");
  a_mul_sign: assert property (
    ln_c && w_q[7:6] == 2'h3 |-> dec.signed_op == w_q[8]) else $error("mul sign");
  a_dadd_loc: assert property (
    ln_c && w_q[8:4] == 5'h10 |-> dec.mem_to_mem == w_q[3]) else $error("dadd location");
  a_dadd_pre: assert property (
    ln_c && w_q[8:3] == 6'h21 |-> dec.predec && dec.x_is_addr && dec.y_is_addr)
    else $error("dadd predec");
  a_and_dest: assert property (
    ln_c && w_q[7:6] != 2'h3 && (!w_q[8] || w_q[5:4] != 2'h0) |-> {dec.to_ea, dec.size} == w_q[8:6])
    else $error("and opmode");
  a_route_grp: assert property (
    pv && !(w_q[15:12] inside {4'h9, 4'hB, 4'hC}) |-> dec_unknown) else $error("route");
  a_bus_wait: assert property (
    hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout) else $error("wait state");
  c_sub: cover property (sub && w_q[3]);
  c_unk: cover property (pv && dec_unknown);
  c_bus: cover property (hsel && htrans[1] && hready);
endmodule
bind ofd_decoder_top ofd_decoder_props #(.CNT_W(CNT_W)) u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hready(hready),
  .hreadyout(hreadyout), .op_word(op_word), .op_valid(op_valid), .dec(dec),
  .dec_valid(dec_valid), .dec_unknown(dec_unknown)
);

// file: ofd_decoder_top.sv
`timescale 1ns/1ps
module ofd_decoder_top #(
  parameter int unsigned CNT_W = ofd_pkg::CNT_W
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // instruction pipeline
  input wire logic [15:0] op_word,
  input wire logic op_valid,
  // execution datapath
  output ofd_pkg::ofd_decode_type dec,
  output logic dec_valid,
  output logic dec_unknown
);

  // bus phase state
  logic pend_q;
  logic pend_d;
  logic pend_wr_q;
  logic pend_wr_d;
  logic [ofd_pkg::OFS_W-1:0] pend_addr_q;
  logic [ofd_pkg::OFS_W-1:0] pend_addr_d;
  logic hready_q;
  logic hready_d;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  logic accept;

  // software registers
  logic [ofd_pkg::CTRL_W-1:0] ctrl_q;
  logic [ofd_pkg::CTRL_W-1:0] ctrl_d;
  logic [15:0] sw_word_q;
  logic [15:0] sw_word_d;
  logic sw_go_q;
  logic sw_go_d;
  logic cnt_clr;

  // decode state
  ofd_pkg::ofd_decode_type dec_q;
  ofd_pkg::ofd_decode_type dec_d;
  logic valid_q;
  logic valid_d;
  logic unknown_q;
  logic unknown_d;
  logic [15:0] last_q;
  logic [15:0] last_d;
  logic [CNT_W-1:0] cnt_ok_q;
  logic [CNT_W-1:0] cnt_ok_d;
  logic [CNT_W-1:0] cnt_bad_q;
  logic [CNT_W-1:0] cnt_bad_d;

  // decoder feed
  logic [15:0] feed_word;
  logic feed_valid;
  ofd_pkg::ofd_decode_type feed_dec;
  logic feed_known;

  function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] cur,
                                                input logic clr, input logic inc);
    logic [CNT_W-1:0] base;
    base = clr ? '0 : cur;
    // an increment in the clear cycle still counts
    if (inc && base != '1)
      cnt_step = base + CNT_W'(1);
    else
      cnt_step = base;
  endfunction

  ofd_field_decode u_decode (
    .word(feed_word),
    .dec(feed_dec),
    .known(feed_known)
  );

  assign accept = hsel && htrans[1] && hready;

  // bus slave: one wait state, then data phase completes
  always_comb
  begin
    pend_d = accept;
    pend_wr_d = pend_wr_q;
    pend_addr_d = pend_addr_q;
    hready_d = !accept;
    hrdata_d = hrdata_q;
    if (accept)
    begin
      pend_wr_d = hwrite;
      pend_addr_d = haddr[ofd_pkg::OFS_W-1:0];
    end
    if (pend_q && !pend_wr_q)
    begin
      hrdata_d = '0;
      unique case (pend_addr_q)
        ofd_pkg::OFS_CTRL:
        begin
          hrdata_d[ofd_pkg::CTRL_W-1:0] = ctrl_q;
        end
        ofd_pkg::OFS_SW_WORD:
        begin
          hrdata_d[15:0] = sw_word_q;
        end
        ofd_pkg::OFS_RESULT:
        begin
          hrdata_d[ofd_pkg::DEC_W-1:0] = dec_q;
          hrdata_d[ofd_pkg::DEC_W] = valid_q;
          hrdata_d[ofd_pkg::DEC_W+1] = unknown_q;
        end
        ofd_pkg::OFS_LAST_WORD:
        begin
          hrdata_d[15:0] = last_q;
        end
        ofd_pkg::OFS_COUNT:
        begin
          hrdata_d[15:0] = 16'(cnt_ok_q);
          hrdata_d[31:16] = 16'(cnt_bad_q);
        end
        default:
        begin
          hrdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_q <= 1'b0;
      pend_wr_q <= 1'b0;
      pend_addr_q <= '0;
      hready_q <= 1'b1;
      hrdata_q <= '0;
    end
    else
    begin
      pend_q <= pend_d;
      pend_wr_q <= pend_wr_d;
      pend_addr_q <= pend_addr_d;
      hready_q <= hready_d;
      hrdata_q <= hrdata_d;
    end
  end

  // register writes commit in the first data-phase cycle
  always_comb
  begin
    ctrl_d = ctrl_q;
    sw_word_d = sw_word_q;
    sw_go_d = 1'b0;
    cnt_clr = 1'b0;
    if (pend_q && pend_wr_q)
    begin
      unique case (pend_addr_q)
        ofd_pkg::OFS_CTRL:
        begin
          ctrl_d = hwdata[ofd_pkg::CTRL_W-1:0];
        end
        ofd_pkg::OFS_SW_WORD:
        begin
          sw_word_d = hwdata[15:0];
          sw_go_d = 1'b1;
        end
        ofd_pkg::OFS_COUNT:
        begin
          cnt_clr = 1'b1;
        end
        default:
        begin
          cnt_clr = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= ofd_pkg::CTRL_RESET;
      sw_word_q <= '0;
      sw_go_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      sw_word_q <= sw_word_d;
      sw_go_q <= sw_go_d;
    end
  end

  // source select: pipeline port or software word
  always_comb
  begin
    if (ctrl_q[ofd_pkg::CTRL_SRC_BIT])
    begin
      feed_word = sw_word_q;
      feed_valid = sw_go_q && ctrl_q[ofd_pkg::CTRL_EN_BIT];
    end
    else
    begin
      feed_word = op_word;
      feed_valid = op_valid && ctrl_q[ofd_pkg::CTRL_EN_BIT];
    end
  end

  // decoded fields held until the next accepted word
  always_comb
  begin
    dec_d = dec_q;
    last_d = last_q;
    valid_d = feed_valid;
    unknown_d = feed_valid && !feed_known;
    if (feed_valid)
    begin
      dec_d = feed_dec;
      last_d = feed_word;
    end
    cnt_ok_d = cnt_step(cnt_ok_q, cnt_clr, feed_valid && feed_known);
    cnt_bad_d = cnt_step(cnt_bad_q, cnt_clr, feed_valid && !feed_known);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dec_q <= '0;
      last_q <= '0;
      valid_q <= 1'b0;
      unknown_q <= 1'b0;
      cnt_ok_q <= '0;
      cnt_bad_q <= '0;
    end
    else
    begin
      dec_q <= dec_d;
      last_q <= last_d;
      valid_q <= valid_d;
      unknown_q <= unknown_d;
      cnt_ok_q <= cnt_ok_d;
      cnt_bad_q <= cnt_bad_d;
    end
  end

  assign hreadyout = hready_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign dec = dec_q;
  assign dec_valid = valid_q;
  assign dec_unknown = unknown_q;

endmodule

// file: ofd_field_decode.sv
`timescale 1ns/1ps
module ofd_field_decode (
  // operation word in
  input wire logic [15:0] word,
  // decoded fields out
  output ofd_pkg::ofd_decode_type dec,
  output logic known
);

  logic [2:0] opm;
  logic [1:0] sz;
  logic loc;

  always_comb
  begin
    opm = word[ofd_pkg::OPM_HI:ofd_pkg::OPM_LO];
    sz = word[ofd_pkg::SIZE_HI:ofd_pkg::SIZE_LO];
    loc = word[ofd_pkg::LOC_BIT];
    dec = '0;
    dec.op = ofd_pkg::OP_NONE;
    dec.size = ofd_pkg::SZ_NONE;
    dec.reg_x = word[ofd_pkg::RX_HI:ofd_pkg::RX_LO];
    dec.reg_y = word[ofd_pkg::RY_HI:ofd_pkg::RY_LO];
    unique case (word[ofd_pkg::GRP_HI:ofd_pkg::GRP_LO])
      ofd_pkg::GRP_SUB:
      begin
        if (word[ofd_pkg::OPM_HI] && sz != ofd_pkg::SZ_NONE
            && word[ofd_pkg::MODE_HI:ofd_pkg::MODE_HI-1] == ofd_pkg::PAT_EXT_5_4)
        begin
          dec.op = ofd_pkg::OP_SUBTRACT_WITH_EXTEND;
          dec.size = ofd_pkg::ofd_size_type'(sz);
          dec.mem_to_mem = loc;
          dec.predec = loc;
          dec.x_is_addr = loc;
          dec.y_is_addr = loc;
        end
      end
      ofd_pkg::GRP_CMP:
      begin
        if (opm[1:0] == ofd_pkg::PAT_OPM_ADDR)
        begin
          dec.op = ofd_pkg::OP_ADDRESS_COMPARE;
          dec.size = opm[2] ? ofd_pkg::SZ_LONG : ofd_pkg::SZ_WORD;
          dec.y_is_addr = 1'b1;
        end
        else if (!opm[2])
        begin
          dec.op = ofd_pkg::OP_DATA_COMPARE;
          dec.size = ofd_pkg::ofd_size_type'(opm[1:0]);
        end
        else if (word[ofd_pkg::MODE_HI:ofd_pkg::MODE_LO] == ofd_pkg::PAT_MODE_AREG)
        begin
          dec.op = ofd_pkg::OP_MEMORY_COMPARE_POSTINCREMENT;
          dec.size = ofd_pkg::ofd_size_type'(opm[1:0]);
          dec.mem_to_mem = 1'b1;
          dec.postinc = 1'b1;
          dec.x_is_addr = 1'b1;
          dec.y_is_addr = 1'b1;
        end
        else
        begin
          dec.op = ofd_pkg::OP_EXCLUSIVE_OR_TO_DESTINATION;
          dec.size = ofd_pkg::ofd_size_type'(opm[1:0]);
          dec.to_ea = 1'b1;
        end
      end
      ofd_pkg::GRP_AND:
      begin
        if (word[ofd_pkg::OPM_HI:ofd_pkg::MODE_HI-1] == ofd_pkg::PAT_DADD_8_4)
        begin
          dec.op = ofd_pkg::OP_DECIMAL_ADD_WITH_EXTEND;
          dec.size = ofd_pkg::SZ_BYTE;
          dec.mem_to_mem = loc;
          dec.predec = loc;
          dec.x_is_addr = loc;
          dec.y_is_addr = loc;
        end
        else if (word[ofd_pkg::OPM_HI:ofd_pkg::MODE_LO] == ofd_pkg::PAT_SWAP_DD
                 || word[ofd_pkg::OPM_HI:ofd_pkg::MODE_LO] == ofd_pkg::PAT_SWAP_AA
                 || word[ofd_pkg::OPM_HI:ofd_pkg::MODE_LO] == ofd_pkg::PAT_SWAP_DA)
        begin
          dec.op = ofd_pkg::OP_REGISTER_SWAP;
          dec.size = ofd_pkg::SZ_LONG;
          dec.x_is_addr = word[ofd_pkg::LOC_BIT];
          dec.y_is_addr = (word[ofd_pkg::OPM_HI:ofd_pkg::MODE_LO] == ofd_pkg::PAT_SWAP_AA);
        end
        else if (opm[1:0] == ofd_pkg::PAT_OPM_ADDR)
        begin
          dec.op = opm[2] ? ofd_pkg::OP_SIGNED_MULTIPLY_WORD
                          : ofd_pkg::OP_UNSIGNED_MULTIPLY_WORD;
          dec.size = ofd_pkg::SZ_WORD;
          dec.signed_op = opm[2];
        end
        else
        begin
          dec.op = ofd_pkg::OP_LOGICAL_AND;
          dec.size = ofd_pkg::ofd_size_type'(opm[1:0]);
          dec.to_ea = opm[2];
        end
      end
      default:
      begin
        dec.op = ofd_pkg::OP_NONE;
      end
    endcase
    known = (dec.op != ofd_pkg::OP_NONE);
  end

endmodule

// file: ofd_pipe_model.sv
`timescale 1ns/1ps
module ofd_pipe_model (
  // clock
  input wire logic hclk,
  // bench request
  input wire logic go,
  input wire logic [15:0] word_in,
  // toward decoder
  output logic [15:0] op_word,
  output logic op_valid
);
  initial op_valid = 1'b0;
  initial op_word = 16'h0000;
  // idle word toggles so stale data never looks held
  always @(posedge hclk)
  begin
    op_valid <= go;
    op_word <= go ? word_in : ~op_word;
  end
endmodule

// file: ofd_pkg.sv
// Functional notes
// - extend-subtract size 00 byte, 01 word, 10 long
// - extend-subtract location bit: 0 reg, 1 memory
// - extend-subtract registers: data, or predecrement address
// - multiply type bit: 0 unsigned, 1 signed
// - decimal add location bit: 0 reg, 1 memory
// - decimal add memory form: address registers, predecrement
// - and opmode gives size and result destination
package ofd_pkg;

  // bus register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SW_WORD = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_LAST_WORD = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam int unsigned OFS_W = 8;

  // control register
  localparam int unsigned CTRL_W = 2;
  localparam int unsigned CTRL_SRC_BIT = 0;
  localparam int unsigned CTRL_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;

  // operation word fields
  localparam int unsigned GRP_HI = 15;
  localparam int unsigned GRP_LO = 12;
  localparam int unsigned RY_HI = 11;
  localparam int unsigned RY_LO = 9;
  localparam int unsigned OPM_HI = 8;
  localparam int unsigned OPM_LO = 6;
  localparam int unsigned SIZE_HI = 7;
  localparam int unsigned SIZE_LO = 6;
  localparam int unsigned MODE_HI = 5;
  localparam int unsigned MODE_LO = 3;
  localparam int unsigned LOC_BIT = 3;
  localparam int unsigned RX_HI = 2;
  localparam int unsigned RX_LO = 0;

  // group codes and fixed patterns
  localparam logic [3:0] GRP_SUB = 4'h9;
  localparam logic [3:0] GRP_CMP = 4'hB;
  localparam logic [3:0] GRP_AND = 4'hC;
  localparam logic [1:0] PAT_EXT_5_4 = 2'h0;
  localparam logic [2:0] PAT_MODE_AREG = 3'h1;
  localparam logic [1:0] PAT_OPM_ADDR = 2'h3;
  localparam logic [4:0] PAT_DADD_8_4 = 5'h10;
  localparam logic [5:0] PAT_SWAP_DD = 6'h28;
  localparam logic [5:0] PAT_SWAP_AA = 6'h29;
  localparam logic [5:0] PAT_SWAP_DA = 6'h31;

  localparam int unsigned WORD_W = 16;
  localparam int unsigned CNT_W = 16;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_SUBTRACT_WITH_EXTEND = 4'h1,
    OP_DATA_COMPARE = 4'h2,
    OP_ADDRESS_COMPARE = 4'h3,
    OP_EXCLUSIVE_OR_TO_DESTINATION = 4'h4,
    OP_MEMORY_COMPARE_POSTINCREMENT = 4'h5,
    OP_LOGICAL_AND = 4'h6,
    OP_UNSIGNED_MULTIPLY_WORD = 4'h7,
    OP_SIGNED_MULTIPLY_WORD = 4'h8,
    OP_DECIMAL_ADD_WITH_EXTEND = 4'h9,
    OP_REGISTER_SWAP = 4'hA
  } ofd_op_type;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2,
    SZ_NONE = 2'h3
  } ofd_size_type;

  typedef struct packed {
    ofd_op_type op;
    ofd_size_type size;
    logic mem_to_mem;
    logic predec;
    logic postinc;
    logic x_is_addr;
    logic y_is_addr;
    logic to_ea;
    logic signed_op;
    logic [2:0] reg_y;
    logic [2:0] reg_x;
  } ofd_decode_type;

  localparam int unsigned DEC_W = $bits(ofd_decode_type);

endpackage

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] wv = 16'h0;
  logic go = 1'b0;
  logic hreadyout, hresp, op_valid, dec_valid, dec_unknown, u, seen;
  logic [31:0] hrdata, rd;
  logic [15:0] op_word;
  ofd_pkg::ofd_decode_type dec, d;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #2.5 hclk = ~hclk;
  ofd_pipe_model PIPE (.hclk(hclk), .go(go), .word_in(wv), .op_word(op_word),
    .op_valid(op_valid));
  ofd_decoder_top #(.CNT_W(16)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .op_word(op_word), .op_valid(op_valid), .dec(dec), .dec_valid(dec_valid),
    .dec_unknown(dec_unknown));
  task chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  // looks at the cycle already under way first, so a pulse right after a bus write is seen
  task watch;
    seen = 1'b0;
    repeat (6)
    begin
      #1;
      if (dec_valid === 1'b1)
      begin
        seen = 1'b1;
        d = dec;
        u = dec_unknown;
      end
      @(posedge hclk);
    end
  endtask
  task send(input logic [15:0] x);
    go <= 1'b1;
    wv <= x;
    @(posedge hclk);
    go <= 1'b0;
    watch;
  endtask
  task t_sub;
    for (int i = 0; i < 6; i++)
    begin
      send({4'h9, 3'h5, 1'b1, 2'(i / 2), 2'h0, i[0], 3'h2});
      chk({7'h0, seen}, 8'h01);
      chk({4'h0, d.op}, {4'h0, ofd_pkg::OP_SUBTRACT_WITH_EXTEND});
      chk({6'h0, d.size}, 8'(i / 2));
      chk({7'h0, d.mem_to_mem}, {7'h0, i[0]});
      chk({5'h0, d.predec, d.x_is_addr, d.y_is_addr}, {5'h0, {3{i[0]}}});
      chk({2'h0, d.reg_y, d.reg_x}, 8'h2A);
    end
    $display("sub done");
  endtask
  task t_mul_dadd;
    for (int i = 0; i < 2; i++)
    begin
      send({4'hC, 3'h1, i[0], 2'h3, 6'h02});
      chk({7'h0, d.signed_op}, {7'h0, i[0]});
      chk({4'h0, d.op}, {4'h0, i[0] ? ofd_pkg::OP_SIGNED_MULTIPLY_WORD :
        ofd_pkg::OP_UNSIGNED_MULTIPLY_WORD});
      send({4'hC, 3'h3, 5'h10, i[0], 3'h4});
      chk({4'h0, d.op}, {4'h0, ofd_pkg::OP_DECIMAL_ADD_WITH_EXTEND});
      chk({7'h0, d.mem_to_mem}, {7'h0, i[0]});
      chk({5'h0, d.predec, d.x_is_addr, d.y_is_addr}, {5'h0, {3{i[0]}}});
    end
    $display("mul dadd done");
  endtask
  task t_and;
    logic [2:0] opm;
    for (int i = 0; i < 6; i++)
    begin
      opm = 3'(i < 3 ? i : i + 1);
      send({4'hC, 3'h1, opm, 6'h10});
      chk({4'h0, d.op}, {4'h0, ofd_pkg::OP_LOGICAL_AND});
      chk({5'h0, d.to_ea, d.size}, {5'h0, opm});
    end
    $display("and done");
  endtask
  task t_route;
    send(16'hD040);
    chk({6'h0, seen, u}, 8'h03);
    send(16'h9FC8);
    chk({6'h0, seen, u}, 8'h03);
    send(16'hB041);
    chk({6'h0, seen, u}, 8'h02);
    chk({4'h0, d.op}, {4'h0, ofd_pkg::OP_DATA_COMPARE});
    $display("route done");
  endtask
  task t_bus;
    ahb(1'b0, ofd_pkg::OFS_CTRL, 32'h0);
    chk(rd[7:0], {6'h0, ofd_pkg::CTRL_RESET});
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd[7:0] | rd[31:24], 8'h00);
    ahb(1'b1, ofd_pkg::OFS_CTRL, 32'h3);
    ahb(1'b1, ofd_pkg::OFS_SW_WORD, 32'hC1C2);
    watch;
    chk({6'h0, seen, d.signed_op}, 8'h03);
    send(16'hC0C2);
    chk({7'h0, seen}, 8'h00);
    ahb(1'b0, ofd_pkg::OFS_LAST_WORD, 32'h0);
    chk(rd[15:8], 8'hC1);
    chk({7'h0, hresp}, 8'h00);
    // known and unknown decode counts from every scenario so far
    ahb(1'b0, ofd_pkg::OFS_COUNT, 32'h0);
    chk(rd[7:0], 8'h12);
    chk(rd[23:16], 8'h02);
    ahb(1'b1, ofd_pkg::OFS_COUNT, 32'h0);
    ahb(1'b0, ofd_pkg::OFS_COUNT, 32'h0);
    chk(rd[7:0] | rd[23:16], 8'h00);
    ahb(1'b1, ofd_pkg::OFS_CTRL, 32'h2);
    $display("bus done");
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_sub;
    t_mul_dadd;
    t_and;
    t_route;
    t_bus;
    print_verdict;
  end
endmodule
